/* dv/ahb_slave_ddr_bridge_tb_top.sv */
`timescale 1ns/1ps
module ahb_slave_ddr_bridge_tb_top;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic hsel = 1'b0;
	logic rsel = 1'b0;
	logic msel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [2:0] hburst = 3'h0;
	logic [31:0] hwdata = '0;
	logic bus_hold = 1'b0;
	logic stall = 1'b0;
	logic hready_in;
	logic hreadyout;
	logic [1:0] hresp;
	logic [31:0] hrdata;
	logic [3:0][31:0] cfg;
	logic req_valid;
	logic req_ready;
	logic rvalid;
	logic [31:0] rdata;
	logic [2:0] last_burst;
	ahbb_pkg::ahbb_req_s req;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	int waits;
	logic [31:0] rd;
	logic [1:0] rp;
	logic double_rate_clock = 1'b1;
	int fast_edges = 0;
	always #5 clk_in = ~clk_in;
	// Starts high so its rising edges land on every bus clock edge
	always #2.5 double_rate_clock = ~double_rate_clock;
	always @(posedge double_rate_clock)
	begin
		fast_edges++;
	end
	// Single slave on the bus: bus ready follows ours unless held
	assign hready_in = hreadyout & !bus_hold;
	ahbb_bridge #(.FIFO_DEPTH(2)) i_dut (.clk_in(clk_in), .srst_in(srst_in), .hsel_in(hsel),
		.register_space_select_in(rsel), .memory_space_select_in(msel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hburst_in(hburst),
		.hwdata_in(hwdata), .hready_in(hready_in), .hreadyout_out(hreadyout),
		.hresp_out(hresp), .hrdata_out(hrdata), .cfg_out(cfg), .mem_req_valid_out(req_valid),
		.mem_req_ready_in(req_ready), .mem_req_out(req), .mem_rdata_valid_in(rvalid),
		.mem_rdata_in(rdata));
	ahbb_mem_model i_mem (.clk_in(clk_in), .srst_in(srst_in), .stall_in(stall),
		.req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
		.rdata_valid_out(rvalid), .rdata_out(rdata), .last_burst_out(last_burst));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic xfer(input logic [1:0] tr, input logic rs, input logic ms, input logic wr,
		input logic [2:0] sz, input logic [2:0] bu, input logic [31:0] ad, input logic [31:0] wd);
		@(negedge clk_in);
		hsel = 1'b1;
		rsel = rs;
		msel = ms;
		haddr = ad;
		htrans = tr;
		hwrite = wr;
		hsize = sz;
		hburst = bu;
		@(negedge clk_in);
		hsel = 1'b0;
		rsel = 1'b0;
		msel = 1'b0;
		htrans = ahbb_pkg::HTRANS_IDLE;
		hwdata = wd;
		waits = 0;
		while (hreadyout !== 1'b1 && waits < 100)
		begin
			waits++;
			@(negedge clk_in);
		end
		if (waits >= 100)
			check(waits, 32'h0, "wait limit");
		rd = hrdata;
		rp = hresp;
	endtask
	task automatic do_reset();
		int edges;
		@(negedge clk_in);
		srst_in = 1'b1;
		#1;
		edges = fast_edges;
		repeat (5) @(negedge clk_in);
		srst_in = 1'b0;
		#1;
		check(fast_edges - edges, 32'hA, "double rate edges");
		check({hreadyout, hresp, req_valid}, 32'h8, "reset flags");
		check(hrdata, 32'h0, "reset rdata");
		check(cfg[0] | cfg[1] | cfg[2] | cfg[3], 32'h0, "reset cfg");
		$display("reset test done");
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 4; i++)
		begin
			xfer(ahbb_pkg::HTRANS_NONSEQ, 1, 0, 1, ahbb_pkg::HSIZE_WORD, 0, i * 4, 32'hA5000000 | i);
			check(waits, 1, "reg write waits");
		end
		for (int i = 0; i < 4; i++)
		begin
			xfer(ahbb_pkg::HTRANS_NONSEQ, 1, 0, 0, ahbb_pkg::HSIZE_WORD, 0, i * 4, 0);
			check(rd, 32'hA5000000 | i, "reg read");
			check({waits[3:0], rp}, 32'h0, "reg read wait");
		end
		xfer(ahbb_pkg::HTRANS_NONSEQ, 1, 0, 1, ahbb_pkg::HSIZE_BYTE, 0, 32'h5, 32'h0000C300);
		xfer(ahbb_pkg::HTRANS_NONSEQ, 1, 0, 1, ahbb_pkg::HSIZE_HALF, 0, 32'hA, 32'h7E5A0000);
		check(cfg[1], 32'hA500C301, "byte lane");
		check(cfg[2], 32'h7E5A0002, "half lanes");
		$display("register test done");
	endtask
	task automatic t_errors();
		logic [2:0] tbl [5] = '{3'h6, 3'h0, 3'h7, 3'h1, 3'h4};
		for (int i = 0; i < 5; i++)
		begin
			xfer(ahbb_pkg::HTRANS_NONSEQ, tbl[i][2], tbl[i][1], 1, {1'b0, tbl[i][0], 1'b0} |
				{tbl[i] == 3'h4, 2'h0}, 0, 0, 32'hFFFFFFFF);
			check({waits[3:0], rp}, {4'h1, ahbb_pkg::HRESP_ERROR}, "error reply");
		end
		xfer(ahbb_pkg::HTRANS_NONSEQ, 1, 0, 1, ahbb_pkg::HSIZE_DWORD, 0, 0, 32'hFFFFFFFF);
		check({waits[3:0], rp}, {4'h1, ahbb_pkg::HRESP_ERROR}, "dword refused");
		check(cfg[0], 32'h0, "refused write");
		xfer(ahbb_pkg::HTRANS_NONSEQ, 1, 0, 0, ahbb_pkg::HSIZE_WORD, 0, 0, 0);
		check(rp, ahbb_pkg::HRESP_OKAY, "okay after error");
		$display("error test done");
	endtask
	task automatic t_idle_hold();
		stall = 1'b1;
		for (int t = 0; t < 2; t++)
		begin
			xfer(t[1:0], 1, 0, 1, ahbb_pkg::HSIZE_WORD, 0, 32'hC, 32'h11111111);
			check({waits[3:0], rp}, 32'h0, "idle reply");
			xfer(t[1:0], 0, 1, 1, ahbb_pkg::HSIZE_WORD, 0, 32'h40, 32'h11111111);
			check({req_valid, cfg[3]}, 32'h0, "idle no activity");
		end
		stall = 1'b0;
		bus_hold = 1'b1;
		xfer(ahbb_pkg::HTRANS_NONSEQ, 1, 0, 1, ahbb_pkg::HSIZE_WORD, 0, 0, 32'h12345678);
		bus_hold = 1'b0;
		check(cfg[0], 32'h0, "bus ready low");
		$display("idle and hold test done");
	endtask
	task automatic t_mem();
		for (int b = 0; b < 8; b++)
		begin
			// Later beats go out as sequential so that transfer type is exercised too
			xfer((b == 0) ? ahbb_pkg::HTRANS_NONSEQ : ahbb_pkg::HTRANS_SEQ, 0, 1, 1,
				ahbb_pkg::HSIZE_WORD, b, 32'h100 + b * 4, 32'hC0DE0000 + b);
			@(negedge clk_in);
			check(last_burst, b, "burst type");
			xfer(ahbb_pkg::HTRANS_NONSEQ, 0, 1, 0, ahbb_pkg::HSIZE_WORD, b, 32'h100 + b * 4, 0);
			check(rd, 32'hC0DE0000 + b, "mem read");
			check(waits >= 2, 1, "mem read waits");
		end
		stall = 1'b1;
		fork
			begin
				repeat (30) @(negedge clk_in);
				stall = 1'b0;
			end
			for (int i = 0; i < 3; i++)
				xfer(ahbb_pkg::HTRANS_NONSEQ, 0, 1, 1, ahbb_pkg::HSIZE_WORD, 1, 32'h200 + i * 4,
					32'hF1F00000 + i);
		join
		check(waits > 5, 1, "full fifo stretches");
		xfer(ahbb_pkg::HTRANS_NONSEQ, 0, 1, 0, ahbb_pkg::HSIZE_WORD, 1, 32'h208, 0);
		check(rd, 32'hF1F00002, "drained write");
		$display("memory test done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			$display("mismatch at %0t: timeout", $time);
			tally_and_finish();
		end
	end
	initial
	begin
		do_reset();
		t_regs();
		do_reset();
		t_errors();
		t_idle_hold();
		t_mem();
		tally_and_finish();
	end
endmodule

/* dv/ahbb_mem_model.sv */
`timescale 1ns/1ps
module ahbb_mem_model #(
	parameter int LAT = 3
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic stall_in,
	input wire logic req_valid_in,
	input wire ahbb_pkg::ahbb_req_s req_in,
	output logic req_ready_out,
	output logic rdata_valid_out,
	output logic [31:0] rdata_out,
	output logic [2:0] last_burst_out
);
	logic [31:0] mem [16];
	logic [31:0] pend;
	int cnt;
	// One read in flight keeps replies in request order
	assign req_ready_out = !stall_in && cnt == 0;
	always @(posedge clk_in)
	begin
		rdata_valid_out <= 1'b0;
		// Return bus is inverted every cycle between replies, so a stale copy never holds for two cycles running
		rdata_out <= ~rdata_out;
		if (srst_in)
		begin
			cnt <= 0;
			rdata_out <= '0;
			last_burst_out <= 3'h0;
		end
		else
		begin
			if (req_valid_in && req_ready_out)
			begin
				last_burst_out <= req_in.burst;
				if (req_in.write)
				begin
					for (int i = 0; i < 4; i++)
						if (req_in.strb[i])
							mem[req_in.addr[5:2]][i*8 +: 8] <= req_in.data[i*8 +: 8];
				end
				else
				begin
					cnt <= LAT;
					pend <= mem[req_in.addr[5:2]];
				end
			end
			if (cnt != 0)
			begin
				cnt <= cnt - 1;
				if (cnt == 1)
				begin
					rdata_valid_out <= 1'b1;
					rdata_out <= pend;
				end
			end
		end
	end
endmodule

/* rtl/ahbb_bridge.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Register select with slave select hits registers
// - Memory select with slave select targets DDR data
// - Ready out high on completion, low stretches
// - Responses are only OKAY or ERROR
// - Incrementing and wrapping 4/8/16 bursts accepted
// - Byte, half, word; doubleword on 64-bit bus
// - Only nonsequential and sequential start data activity
// - Reset returns all interface state to defaults
// - Everything sampled and launched on rising edge
// - New address taken only when bus ready high
module ahbb_bridge #(
	parameter int FIFO_DEPTH = ahbb_pkg::FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic hsel_in,
	input wire logic register_space_select_in,
	input wire logic memory_space_select_in,
	input wire logic [ahbb_pkg::ADDR_W-1:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [2:0] hburst_in,
	input wire logic [ahbb_pkg::DATA_W-1:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic [1:0] hresp_out,
	output logic [ahbb_pkg::DATA_W-1:0] hrdata_out,
	output logic [ahbb_pkg::NCFG-1:0][31:0] cfg_out,
	output logic mem_req_valid_out,
	input wire logic mem_req_ready_in,
	output ahbb_pkg::ahbb_req_s mem_req_out,
	input wire logic mem_rdata_valid_in,
	input wire logic [ahbb_pkg::DATA_W-1:0] mem_rdata_in
);
	typedef struct packed {
		ahbb_pkg::ahbb_state_e st;
		logic hreadyout;
		logic [1:0] hresp;
		logic [ahbb_pkg::DATA_W-1:0] hrdata;
		logic write;
		logic reg_sel;
		logic [2:0] burst;
		logic [2:0] size;
		logic [ahbb_pkg::ADDR_W-1:0] addr;
		logic [ahbb_pkg::NCFG-1:0][31:0] cfg;
	} ahbb_state_s;

	localparam ahbb_state_s STATE_RST = '{
		st: ahbb_pkg::ST_IDLE,
		hreadyout: 1'b1,
		hresp: ahbb_pkg::HRESP_OKAY,
		hrdata: '0,
		write: 1'b0,
		reg_sel: 1'b0,
		burst: '0,
		size: '0,
		addr: '0,
		cfg: {ahbb_pkg::NCFG{ahbb_pkg::CFG_RST}}
	};

	ahbb_state_s q;
	ahbb_state_s next_q;
	ahbb_pkg::ahbb_req_s req;
	logic push;
	logic fifo_ready;
	logic take;
	logic bad;
	logic [ahbb_pkg::STRB_W-1:0] strb;

	// ----------------------------------------
	// Byte lanes of a transfer
	// ----------------------------------------
	function automatic logic [ahbb_pkg::STRB_W-1:0] lane_mask(input logic [2:0] size,
		input logic [ahbb_pkg::ADDR_W-1:0] addr);
		logic [7:0] ones;
		logic [2:0] keep;
		logic [2:0] off;
		logic [7:0] m;
		case (size)
			ahbb_pkg::HSIZE_BYTE: begin ones = 8'h01; keep = 3'h7; end
			ahbb_pkg::HSIZE_HALF: begin ones = 8'h03; keep = 3'h6; end
			ahbb_pkg::HSIZE_WORD: begin ones = 8'h0F; keep = 3'h4; end
			default: begin ones = 8'hFF; keep = 3'h0; end
		endcase
		off = addr[2:0] & keep & 3'(ahbb_pkg::STRB_W - 1);
		m = ones << off;
		return m[ahbb_pkg::STRB_W-1:0];
	endfunction

	// ----------------------------------------
	// Address phase decode
	// ----------------------------------------
	// A stretched data phase holds hready low, so new addresses wait for idle
	assign take = hsel_in && hready_in && htrans_in[1] && (q.st == ahbb_pkg::ST_IDLE);
	// Exactly one space must be selected; oversize transfers fail
	assign bad = (register_space_select_in == memory_space_select_in)
		|| (hsize_in > ahbb_pkg::HSIZE_MAX);
	assign strb = lane_mask(q.size, q.addr);

	always_comb
	begin
		next_q = q;
		push = 1'b0;
		req = '0;
		req.write = q.write;
		req.burst = q.burst;
		req.size = q.size;
		req.addr = q.addr;
		req.strb = strb;
		case (q.st)
			ahbb_pkg::ST_IDLE:
			begin
				next_q.hresp = ahbb_pkg::HRESP_OKAY;
				next_q.hreadyout = 1'b1;
				if (take)
				begin
					next_q.write = hwrite_in;
					next_q.reg_sel = register_space_select_in;
					next_q.burst = hburst_in;
					next_q.size = hsize_in;
					next_q.addr = haddr_in;
					if (bad)
					begin
						next_q.st = ahbb_pkg::ST_ERR;
						next_q.hresp = ahbb_pkg::HRESP_ERROR;
						next_q.hreadyout = 1'b0;
					end
					else if (register_space_select_in && !hwrite_in)
					begin
						// Register reads need no wait state
						next_q.hrdata = '0;
						next_q.hrdata[31:0] = q.cfg[haddr_in[ahbb_pkg::CFG_IDX_LSB +:
							ahbb_pkg::CFG_IDX_W]];
					end
					else
					begin
						next_q.st = hwrite_in ? ahbb_pkg::ST_WDATA : ahbb_pkg::ST_RREQ;
						next_q.hreadyout = 1'b0;
					end
				end
			end
			ahbb_pkg::ST_WDATA:
			begin
				if (q.reg_sel)
				begin
					for (int b = 0; b < 4; b++)
					begin
						if (strb[b])
						begin
							next_q.cfg[q.addr[ahbb_pkg::CFG_IDX_LSB +: ahbb_pkg::CFG_IDX_W]][8*b +: 8]
								= hwdata_in[8*b +: 8];
						end
					end
					next_q.st = ahbb_pkg::ST_IDLE;
					next_q.hreadyout = 1'b1;
				end
				else
				begin
					// Full FIFO keeps the data phase stretched
					req.data = hwdata_in;
					push = 1'b1;
					if (fifo_ready)
					begin
						next_q.st = ahbb_pkg::ST_IDLE;
						next_q.hreadyout = 1'b1;
					end
				end
			end
			ahbb_pkg::ST_RREQ:
			begin
				// Reads queue behind earlier posted writes, so order is kept
				push = 1'b1;
				if (fifo_ready)
				begin
					next_q.st = ahbb_pkg::ST_RWAIT;
				end
			end
			ahbb_pkg::ST_RWAIT:
			begin
				if (mem_rdata_valid_in)
				begin
					next_q.hrdata = mem_rdata_in;
					next_q.hreadyout = 1'b1;
					next_q.st = ahbb_pkg::ST_IDLE;
				end
			end
			ahbb_pkg::ST_ERR:
			begin
				// Second cycle of the two-cycle error answer
				next_q.hreadyout = 1'b1;
				next_q.hresp = ahbb_pkg::HRESP_ERROR;
				next_q.st = ahbb_pkg::ST_IDLE;
			end
			default:
			begin
				next_q = STATE_RST;
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			q <= STATE_RST;
		end
		else
		begin
			q <= next_q;
		end
	end

	ahbb_fifo #(
		.W(ahbb_pkg::REQ_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.in_valid_in(push),
		.in_ready_out(fifo_ready),
		.in_data_in(req),
		.out_valid_out(mem_req_valid_out),
		.out_ready_in(mem_req_ready_in),
		.out_data_out(mem_req_out)
	);

	assign hreadyout_out = q.hreadyout;
	assign hresp_out = q.hresp;
	assign hrdata_out = q.hrdata;
	assign cfg_out = q.cfg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	sequence s_err_answer;
		(hresp_out == ahbb_pkg::HRESP_ERROR && !hreadyout_out)
		##1 (hresp_out == ahbb_pkg::HRESP_ERROR && hreadyout_out);
	endsequence

	sequence s_stretch;
		!hreadyout_out && hresp_out == ahbb_pkg::HRESP_OKAY;
	endsequence

	property p_reg_route;
		take && !bad && register_space_select_in && hwrite_in |=> s_stretch ##1 hreadyout_out;
	endproperty
	a_reg_route: assert property (p_reg_route) else $error("register write not two cycles");

	property p_mem_route;
		take && !bad && memory_space_select_in |=> q.st inside {ahbb_pkg::ST_WDATA,
			ahbb_pkg::ST_RREQ};
	endproperty
	a_mem_route: assert property (p_mem_route) else $error("memory transfer not routed");

	property p_push_done;
		q.st == ahbb_pkg::ST_WDATA && !q.reg_sel && fifo_ready |=> hreadyout_out
			&& q.st == ahbb_pkg::ST_IDLE;
	endproperty
	a_push_done: assert property (p_push_done) else $error("write not completed on push");

	property p_resp_legal;
		hresp_out[1] == 1'b0;
	endproperty
	a_resp_legal: assert property (p_resp_legal) else $error("retry or split answered");

	property p_bad_err;
		take && bad |=> s_err_answer;
	endproperty
	a_bad_err: assert property (p_bad_err) else $error("illegal transfer not errored");

	property p_burst_ok;
		take && !bad && htrans_in == ahbb_pkg::HTRANS_SEQ |=> hresp_out == ahbb_pkg::HRESP_OKAY;
	endproperty
	a_burst_ok: assert property (p_burst_ok) else $error("burst beat refused");

	property p_no_activity;
		q.st == ahbb_pkg::ST_IDLE && hsel_in && !htrans_in[1] |=> hreadyout_out
			&& hresp_out == ahbb_pkg::HRESP_OKAY && !push;
	endproperty
	a_no_activity: assert property (p_no_activity) else $error("idle or busy started work");

	property p_reset;
		@(posedge clk_in) disable iff (1'b0) srst_in |=> hreadyout_out
			&& hresp_out == ahbb_pkg::HRESP_OKAY && !mem_req_valid_out;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

	property p_hold_addr;
		q.st == ahbb_pkg::ST_IDLE && !hready_in |=> q.st == ahbb_pkg::ST_IDLE;
	endproperty
	a_hold_addr: assert property (p_hold_addr) else $error("address taken while bus busy");

	property p_rdata;
		q.st == ahbb_pkg::ST_RWAIT && mem_rdata_valid_in |=> hreadyout_out
			&& hrdata_out == $past(mem_rdata_in);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data not with ready");
endmodule

/* rtl/ahbb_fifo.sv */
`timescale 1ns/1ps
module ahbb_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
	localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} ahbb_fifo_s;

	ahbb_fifo_s q;
	ahbb_fifo_s next_q;
	logic do_push;
	logic do_pop;

	// ----------------------------------------
	// Flags come from the count flops only
	// ----------------------------------------
	assign in_ready_out = (q.count != FULL_CNT);
	assign out_valid_out = (q.count != '0);
	assign out_data_out = q.mem[q.rd];
	assign do_push = in_valid_in && in_ready_out;
	assign do_pop = out_valid_out && out_ready_in;

	always_comb
	begin
		next_q = q;
		if (do_push)
		begin
			next_q.mem[q.wr] = in_data_in;
			next_q.wr = (q.wr == LAST_PTR) ? '0 : q.wr + 1'b1;
		end
		if (do_pop)
		begin
			next_q.rd = (q.rd == LAST_PTR) ? '0 : q.rd + 1'b1;
		end
		if (do_push && !do_pop)
		begin
			next_q.count = q.count + 1'b1;
		end
		else if (do_pop && !do_push)
		begin
			next_q.count = q.count - 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			q <= '0;
		end
		else
		begin
			q <= next_q;
		end
	end
endmodule

/* rtl/ahbb_pkg.sv */
package ahbb_pkg;
	// ----------------------------------------
	// Widths and depths
	// ----------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam int NCFG = 4;
	localparam int CFG_IDX_W = 2;
	localparam int CFG_IDX_LSB = 2;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------
	// Bus encodings
	// ----------------------------------------
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_BUSY = 2'h1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	localparam logic [1:0] HRESP_ERROR = 2'h1;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [2:0] HSIZE_HALF = 3'h1;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [2:0] HSIZE_DWORD = 3'h3;
	localparam logic [2:0] HSIZE_MAX = (DATA_W == 64) ? HSIZE_DWORD : HSIZE_WORD;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] CFG_RST = 32'h0000_0000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic write;
		logic [2:0] burst;
		logic [2:0] size;
		logic [ADDR_W-1:0] addr;
		logic [STRB_W-1:0] strb;
		logic [DATA_W-1:0] data;
	} ahbb_req_s;

	localparam int REQ_W = $bits(ahbb_req_s);

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WDATA = 5'h02,
		ST_RREQ = 5'h04,
		ST_RWAIT = 5'h08,
		ST_ERR = 5'h10
	} ahbb_state_e;
endpackage
